// [shared/ptpts_pkg.sv]
// constants for the per-port time protocol register set
package ptpts_pkg;
  localparam int PTPTS_ADDR_W = 9;
  localparam int PTPTS_PORT_W = 2;
  localparam int PTPTS_BANK_W = 3;
  localparam int PTPTS_CNT_W = 3;

  // register byte offsets
  localparam logic [8:0] PTPTS_SEL_OFS = 9'h000;
  localparam logic [8:0] PTPTS_LAT_OFS = 9'h154;
  localparam logic [8:0] PTPTS_PARSE_OFS = 9'h158;
  localparam logic [8:0] PTPTS_ASYM_OFS = 9'h15C;
  localparam logic [8:0] PTPTS_CAP_OFS = 9'h160;

  // bank codes
  localparam logic [2:0] PTPTS_BANK_PORT = 3'h0;
  localparam logic [2:0] PTPTS_BANK_CFG = 3'h1;

  // select register layout
  localparam int PTPTS_SEL_BANK_LSB = 0;
  localparam int PTPTS_SEL_PORT_LSB = 4;

  // receive parse register layout: bits 14..11
  localparam int PTPTS_PARSE_LSB = 11;
  localparam int PTPTS_PARSE_W = 4;
  localparam logic [3:0] PTPTS_PARSE_RESET = 4'hE;
  localparam int PTPTS_L2A_BIT = 3;
  localparam int PTPTS_L2B_BIT = 2;
  localparam int PTPTS_IP129_BIT = 1;
  localparam int PTPTS_IP130_BIT = 0;

  // capture information layout
  localparam int PTPTS_CAP_TX_LSB = 4;
  localparam int PTPTS_CAP_RX_LSB = 0;
  localparam logic [2:0] PTPTS_CNT_RESET = 3'h0;

  // asymmetry / peer delay register
  localparam logic [31:0] PTPTS_ASYM_RESET = 32'h0000_0000;

  // latency resets in ns: {tx, rx}
  localparam logic [15:0] PTPTS_P0_TX_LAT = 16'h0014;
  localparam logic [15:0] PTPTS_P0_RX_LAT = 16'h0014;
  localparam logic [15:0] PTPTS_PHY_TX_LAT = 16'h005F;
  localparam logic [15:0] PTPTS_PHY_RX_LAT = 16'h011D;

  // reserved destination addresses
  localparam logic [47:0] PTPTS_MAC_L2A = 48'h0180_C200_000E;
  localparam logic [47:0] PTPTS_MAC_L2B = 48'h011B_1900_0000;
  localparam logic [47:0] PTPTS_MAC_V4_129 = 48'h0100_5E00_0181;
  localparam logic [47:0] PTPTS_MAC_V6_129 = 48'h3333_0000_0181;
  localparam logic [47:0] PTPTS_MAC_V4_130 = 48'h0100_5E00_0182;
  localparam logic [47:0] PTPTS_MAC_V6_130 = 48'h3333_0000_0182;
endpackage

// [rtl/ptpts_stamp_counter.sv]
// saturating pending-timestamp counter
`timescale 1ns/1ps
module ptpts_stamp_counter #(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic incr,
  input wire logic decr,
  output logic [WIDTH-1:0] count
);
  import ptpts_pkg::*;

  localparam logic [WIDTH-1:0] CNT_MAX = {WIDTH{1'b1}};
  localparam logic [WIDTH-1:0] CNT_ZERO = WIDTH'(PTPTS_CNT_RESET);
  localparam logic [WIDTH-1:0] CNT_ONE = WIDTH'(1);

  wire canUp = incr && !decr && (count != CNT_MAX);
  wire canDown = decr && !incr && (count != CNT_ZERO);
  logic [WIDTH-1:0] next_count;

  // packet and clear in one cycle cancel, so neither is lost
  assign next_count = canUp ? count + CNT_ONE : canDown ? count - CNT_ONE : count;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= CNT_ZERO;
    end else begin
      count <= next_count;
    end
  end

  cnt_inc_a: assert property (@(posedge clk) disable iff (!resetn)
    incr && !decr && count != CNT_MAX |=> count == $past(count) + CNT_ONE)
    else $error("pending count did not rise on a stamp");
  cnt_dec_a: assert property (@(posedge clk) disable iff (!resetn)
    decr && !incr && count != CNT_ZERO |=> count == $past(count) - CNT_ONE)
    else $error("pending count did not fall on a flag clear");
  cnt_sat_a: assert property (@(posedge clk) disable iff (!resetn)
    (count == CNT_MAX && incr) or (count == CNT_ZERO && decr && !incr) |=> $stable(count))
    else $error("pending count wrapped");
endmodule

// [rtl/ptpts_port_regs.sv]
// per-port time protocol register set behind an avalon-mm slave
`timescale 1ns/1ps
module ptpts_port_regs #(
  parameter int PORTS = 3
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [ptpts_pkg::PTPTS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [PORTS-1:0] rxStampEvent,
  input wire logic [PORTS-1:0] txStampEvent,
  input wire logic [PORTS-1:0] rxStampIrqFlagWrite,
  input wire logic [PORTS-1:0] txStampIrqFlagWrite,
  input wire logic rxDestValid,
  input wire logic [ptpts_pkg::PTPTS_PORT_W-1:0] rxDestPort,
  input wire logic [47:0] rxDestMac,
  output logic rxPtpDestValid,
  output logic rxPtpDest,
  input wire logic capValid,
  input wire logic capIsTx,
  input wire logic [ptpts_pkg::PTPTS_PORT_W-1:0] capPort,
  input wire logic [31:0] capNs,
  output logic corrValid,
  output logic [31:0] corrNs,
  output logic [PORTS*16-1:0] pathAsymmetryNs,
  output logic [PORTS*16-1:0] peerDelayNs
);
  import ptpts_pkg::*;

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wdata,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] latencyReset(input int port);
    return (port == 0) ? {PTPTS_P0_TX_LAT, PTPTS_P0_RX_LAT}
                       : {PTPTS_PHY_TX_LAT, PTPTS_PHY_RX_LAT};
  endfunction

  function automatic logic isPtpMac(input logic [47:0] mac, input logic [3:0] en);
    return (en[PTPTS_L2A_BIT] && mac == PTPTS_MAC_L2A)
      || (en[PTPTS_L2B_BIT] && mac == PTPTS_MAC_L2B)
      || (en[PTPTS_IP129_BIT] && (mac == PTPTS_MAC_V4_129 || mac == PTPTS_MAC_V6_129))
      || (en[PTPTS_IP130_BIT] && (mac == PTPTS_MAC_V4_130 || mac == PTPTS_MAC_V6_130));
  endfunction

  function automatic logic portInRange(input logic [PTPTS_PORT_W-1:0] port);
    return 32'(port) < PORTS;
  endfunction

  logic [PTPTS_BANK_W-1:0] bankSel;
  logic [PTPTS_PORT_W-1:0] portSel;
  logic [31:0] asymPeer [PORTS];
  logic [31:0] latency [PORTS];
  logic [PTPTS_PARSE_W-1:0] parseEn [PORTS];
  logic [PTPTS_CNT_W-1:0] rxCount [PORTS];
  logic [PTPTS_CNT_W-1:0] txCount [PORTS];

  // bus decode
  wire [8:0] alignedAddr = {avs_address[8:2], 2'b00};
  wire portOk = portInRange(portSel);
  wire portBank = bankSel == PTPTS_BANK_PORT;
  wire cfgBank = bankSel == PTPTS_BANK_CFG;
  wire hitSel = alignedAddr == PTPTS_SEL_OFS;
  wire hitLat = alignedAddr == PTPTS_LAT_OFS && portBank && portOk;
  wire hitAsym = alignedAddr == PTPTS_ASYM_OFS && portBank && portOk;
  wire hitCap = alignedAddr == PTPTS_CAP_OFS && portBank && portOk;
  wire hitParse = alignedAddr == PTPTS_PARSE_OFS && cfgBank && portOk;
  wire reqOpen = (avs_read || avs_write) && avs_waitrequest;
  wire wrDone = avs_write && !avs_waitrequest;

  wire [31:0] selWord = (32'(bankSel) << PTPTS_SEL_BANK_LSB) | (32'(portSel) << PTPTS_SEL_PORT_LSB);
  wire [2:0] selRx = rxCount[portSel];
  wire [2:0] selTx = txCount[portSel];
  wire [31:0] capWord = (32'(selTx) << PTPTS_CAP_TX_LSB) | (32'(selRx) << PTPTS_CAP_RX_LSB);
  wire [31:0] parseWord = 32'(parseEn[portSel]) << PTPTS_PARSE_LSB;
  wire [31:0] readValue = hitSel ? selWord
                        : hitLat ? latency[portSel]
                        : hitAsym ? asymPeer[portSel]
                        : hitCap ? capWord
                        : hitParse ? parseWord
                        : 32'h0000_0000;
  wire [31:0] selMerged = mergeBytes(selWord, avs_writedata, avs_byteenable);

  // one wait cycle, then the request completes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !reqOpen;
      if (reqOpen && avs_read) begin
        avs_readdata <= readValue;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bankSel <= PTPTS_BANK_PORT;
      portSel <= '0;
    end else if (wrDone && hitSel) begin
      bankSel <= selMerged[PTPTS_SEL_BANK_LSB +: PTPTS_BANK_W];
      portSel <= selMerged[PTPTS_SEL_PORT_LSB +: PTPTS_PORT_W];
    end
  end

  for (genvar p = 0; p < PORTS; p++) begin : g_port
    wire portHit = portSel == PTPTS_PORT_W'(p);
    wire [31:0] parseMerged = mergeBytes(parseWord, avs_writedata, avs_byteenable);

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        asymPeer[p] <= PTPTS_ASYM_RESET;
      end else if (wrDone && hitAsym && portHit) begin
        asymPeer[p] <= mergeBytes(asymPeer[p], avs_writedata, avs_byteenable);
      end
    end

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        latency[p] <= latencyReset(p);
      end else if (wrDone && hitLat && portHit) begin
        latency[p] <= mergeBytes(latency[p], avs_writedata, avs_byteenable);
      end
    end

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        parseEn[p] <= PTPTS_PARSE_RESET;
      end else if (wrDone && hitParse && portHit) begin
        parseEn[p] <= parseMerged[PTPTS_PARSE_LSB +: PTPTS_PARSE_W];
      end
    end

    ptpts_stamp_counter #(.WIDTH(PTPTS_CNT_W)) u_rx_count (
      .clk(clk),
      .resetn(resetn),
      .incr(rxStampEvent[p]),
      .decr(rxStampIrqFlagWrite[p]),
      .count(rxCount[p])
    );

    ptpts_stamp_counter #(.WIDTH(PTPTS_CNT_W)) u_tx_count (
      .clk(clk),
      .resetn(resetn),
      .incr(txStampEvent[p]),
      .decr(txStampIrqFlagWrite[p]),
      .count(txCount[p])
    );

    // signed, positive when the forward path is the longer one
    assign pathAsymmetryNs[p*16 +: 16] = asymPeer[p][31:16];
    assign peerDelayNs[p*16 +: 16] = asymPeer[p][15:0];
  end

  // destination classification against the per-port enables
  wire destPortOk = portInRange(rxDestPort);
  wire [3:0] destEn = parseEn[rxDestPort];
  wire next_rxPtpDest = destPortOk && isPtpMac(rxDestMac, destEn);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxPtpDestValid <= 1'b0;
      rxPtpDest <= 1'b0;
    end else begin
      rxPtpDestValid <= rxDestValid;
      rxPtpDest <= rxDestValid && next_rxPtpDest;
    end
  end

  // timestamp correction to the first symbol after the delimiter
  wire capPortOk = portInRange(capPort);
  wire [31:0] capLat = latency[capPort];
  wire [31:0] txLat = capPortOk ? 32'(capLat[31:16]) : 32'h0000_0000;
  wire [31:0] rxLat = capPortOk ? 32'(capLat[15:0]) : 32'h0000_0000;
  wire [31:0] next_corrNs = capIsTx ? capNs - txLat : capNs + rxLat;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      corrValid <= 1'b0;
      corrNs <= 32'h0000_0000;
    end else begin
      corrValid <= capValid;
      if (capValid) begin
        corrNs <= next_corrNs;
      end
    end
  end

  asym_write_a: assert property (@(posedge clk) disable iff (!resetn)
    wrDone && hitAsym && avs_byteenable == 4'hF
    |=> asymPeer[$past(portSel)][31:16] == $past(avs_writedata[31:16]))
    else $error("asymmetry field not written");
  peer_write_a: assert property (@(posedge clk) disable iff (!resetn)
    wrDone && hitAsym && avs_byteenable == 4'hF
    |=> asymPeer[$past(portSel)][15:0] == $past(avs_writedata[15:0]))
    else $error("peer delay field not written");
  cap_read_a: assert property (@(posedge clk) disable iff (!resetn)
    reqOpen && avs_read && hitCap
    |=> !avs_waitrequest && avs_readdata == $past(capWord) && avs_readdata[31:7] == '0
        && avs_readdata[3] == 1'b0)
    else $error("capture info read wrong");
  cap_ro_a: assert property (@(posedge clk) disable iff (!resetn)
    wrDone && hitCap && !rxStampEvent[portSel] && !txStampEvent[portSel]
      && !rxStampIrqFlagWrite[portSel] && !txStampIrqFlagWrite[portSel]
    |=> rxCount[$past(portSel)] == $past(rxCount[portSel])
        && txCount[$past(portSel)] == $past(txCount[portSel]))
    else $error("capture info changed by a write");
  bank_gate_a: assert property (@(posedge clk) disable iff (!resetn)
    reqOpen && avs_read && alignedAddr == PTPTS_ASYM_OFS && cfgBank
    |=> avs_readdata == 32'h0000_0000)
    else $error("asymmetry answered in the wrong bank");
  port_gate_a: assert property (@(posedge clk) disable iff (!resetn)
    reqOpen && avs_read && hitSel == 1'b0 && !portOk
    |=> avs_readdata == 32'h0000_0000)
    else $error("absent port answered");
  l2a_accept_a: assert property (@(posedge clk) disable iff (!resetn)
    rxDestValid && destPortOk && rxDestMac == PTPTS_MAC_L2A
    |=> rxPtpDestValid && rxPtpDest == $past(destEn[PTPTS_L2A_BIT]))
    else $error("layer-2 address A decision wrong");
  l2b_accept_a: assert property (@(posedge clk) disable iff (!resetn)
    rxDestValid && destPortOk && rxDestMac == PTPTS_MAC_L2B
    |=> rxPtpDest == $past(destEn[PTPTS_L2B_BIT]))
    else $error("layer-2 address B decision wrong");
  grp129_accept_a: assert property (@(posedge clk) disable iff (!resetn)
    rxDestValid && destPortOk && rxDestMac == PTPTS_MAC_V6_129
    |=> rxPtpDest == $past(destEn[PTPTS_IP129_BIT]))
    else $error("group 129 decision wrong");
  grp130_accept_a: assert property (@(posedge clk) disable iff (!resetn)
    rxDestValid && destPortOk && rxDestMac == PTPTS_MAC_V4_130
    |=> rxPtpDest == $past(destEn[PTPTS_IP130_BIT]))
    else $error("group 130 decision wrong");
  tx_corr_a: assert property (@(posedge clk) disable iff (!resetn)
    capValid && capIsTx && capPortOk
    |=> corrValid && corrNs == $past(capNs) - 32'($past(capLat[31:16])))
    else $error("transmit latency not subtracted");
  rx_corr_a: assert property (@(posedge clk) disable iff (!resetn)
    capValid && !capIsTx && capPortOk
    |=> corrValid && corrNs == $past(capNs) + 32'($past(capLat[15:0])))
    else $error("receive latency not added");
  wait_idle_a: assert property (@(posedge clk) disable iff (!resetn)
    !avs_read && !avs_write
    |=> avs_waitrequest)
    else $error("waitrequest low without a request");
  wait_one_a: assert property (@(posedge clk) disable iff (!resetn)
    reqOpen
    |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  rd_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    !(reqOpen && avs_read)
    |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  sel_read_a: assert property (@(posedge clk) disable iff (!resetn)
    reqOpen && avs_read && hitSel
    |=> avs_readdata[PTPTS_SEL_BANK_LSB +: PTPTS_BANK_W] == $past(bankSel))
    else $error("bank field read wrong");
  bank_write_a: assert property (@(posedge clk) disable iff (!resetn)
    wrDone && hitSel && avs_byteenable[0]
    |=> bankSel == $past(avs_writedata[PTPTS_SEL_BANK_LSB +: PTPTS_BANK_W]))
    else $error("bank field not written");
  port_write_a: assert property (@(posedge clk) disable iff (!resetn)
    wrDone && hitSel && avs_byteenable[0]
    |=> portSel == $past(avs_writedata[PTPTS_SEL_PORT_LSB +: PTPTS_PORT_W]))
    else $error("port field not written");
  lat_gate_a: assert property (@(posedge clk) disable iff (!resetn)
    reqOpen && avs_read && alignedAddr == PTPTS_LAT_OFS && cfgBank
    |=> avs_readdata == 32'h0000_0000)
    else $error("latency answered in the wrong bank");
  parse_gate_a: assert property (@(posedge clk) disable iff (!resetn)
    reqOpen && avs_read && alignedAddr == PTPTS_PARSE_OFS && portBank
    |=> avs_readdata == 32'h0000_0000)
    else $error("parse enables answered in the wrong bank");
  asym_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    !(wrDone && hitAsym)
    |=> $stable(pathAsymmetryNs) && $stable(peerDelayNs))
    else $error("asymmetry changed without a write");
  cap_tx_field_a: assert property (@(posedge clk) disable iff (!resetn)
    reqOpen && avs_read && hitCap
    |=> avs_readdata[PTPTS_CAP_TX_LSB +: PTPTS_CNT_W] == $past(txCount[portSel]))
    else $error("transmit count read from the wrong field");
  cap_rx_field_a: assert property (@(posedge clk) disable iff (!resetn)
    reqOpen && avs_read && hitCap
    |=> avs_readdata[PTPTS_CAP_RX_LSB +: PTPTS_CNT_W] == $past(rxCount[portSel]))
    else $error("receive count read from the wrong field");
  parse_write_a: assert property (@(posedge clk) disable iff (!resetn)
    wrDone && hitParse && avs_byteenable[1]
    |=> parseEn[$past(portSel)] == $past(avs_writedata[PTPTS_PARSE_LSB +: PTPTS_PARSE_W]))
    else $error("parse enables not written");
  parse_read_a: assert property (@(posedge clk) disable iff (!resetn)
    reqOpen && avs_read && hitParse
    |=> (avs_readdata >> (PTPTS_PARSE_LSB + PTPTS_PARSE_W)) == 32'h0000_0000
        && avs_readdata[PTPTS_PARSE_LSB-1:0] == '0)
    else $error("reserved parse bits not zero");
  rx_lat_write_a: assert property (@(posedge clk) disable iff (!resetn)
    wrDone && hitLat && avs_byteenable[1:0] == 2'b11
    |=> latency[$past(portSel)][15:0] == $past(avs_writedata[15:0]))
    else $error("receive latency not written");
  dv_idle_a: assert property (@(posedge clk) disable iff (!resetn)
    !rxDestValid
    |=> !rxPtpDestValid && !rxPtpDest)
    else $error("classification reported without a request");
  absent_dest_a: assert property (@(posedge clk) disable iff (!resetn)
    rxDestValid && !destPortOk
    |=> rxPtpDestValid && !rxPtpDest)
    else $error("absent port accepted a frame");
  grp129_v4_a: assert property (@(posedge clk) disable iff (!resetn)
    rxDestValid && destPortOk && rxDestMac == PTPTS_MAC_V4_129
    |=> rxPtpDest == $past(destEn[PTPTS_IP129_BIT]))
    else $error("group 129 ipv4 decision wrong");
  grp130_v6_a: assert property (@(posedge clk) disable iff (!resetn)
    rxDestValid && destPortOk && rxDestMac == PTPTS_MAC_V6_130
    |=> rxPtpDest == $past(destEn[PTPTS_IP130_BIT]))
    else $error("group 130 ipv6 decision wrong");
  corr_idle_a: assert property (@(posedge clk) disable iff (!resetn)
    !capValid
    |=> !corrValid && $stable(corrNs))
    else $error("corrected stamp changed without a capture");
  absent_corr_a: assert property (@(posedge clk) disable iff (!resetn)
    capValid && !capPortOk
    |=> corrValid && corrNs == $past(capNs))
    else $error("absent port stamp was corrected");
endmodule

// [bench/ptpts_port_regs_bench.sv]
// self-checking bench for the per-port time protocol register set
`timescale 1ns/1ps
`define CHK(got, exp) begin testsRun++; if ((got) !== (exp)) begin errCount++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module ptpts_port_regs_bench;
  import ptpts_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [PTPTS_ADDR_W-1:0] avsAddress = '0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = '0;
  logic [3:0] avsByteenable = 4'hF;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  logic [2:0] rxEv = '0, txEv = '0, rxClr = '0, txClr = '0;
  logic rxDestValid = 1'b0;
  logic [PTPTS_PORT_W-1:0] rxDestPort = '0;
  logic [47:0] rxDestMac = '0;
  logic rxPtpDestValid, rxPtpDest, corrValid;
  logic capValid = 1'b0, capIsTx = 1'b0;
  logic [PTPTS_PORT_W-1:0] capPort = '0;
  logic [31:0] capNs = '0;
  logic [31:0] corrNs;
  logic [47:0] pathAsymmetryNs, peerDelayNs;
  int errCount = 0;
  int testsRun = 0;

  always #25 clk = ~clk;

  ptpts_port_regs #(.PORTS(3)) i_dut (.clk(clk), .resetn(resetn), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
    .avs_byteenable(avsByteenable), .avs_readdata(avsReaddata),
    .avs_waitrequest(avsWaitrequest), .rxStampEvent(rxEv), .txStampEvent(txEv),
    .rxStampIrqFlagWrite(rxClr), .txStampIrqFlagWrite(txClr), .rxDestValid(rxDestValid),
    .rxDestPort(rxDestPort), .rxDestMac(rxDestMac), .rxPtpDestValid(rxPtpDestValid),
    .rxPtpDest(rxPtpDest), .capValid(capValid), .capIsTx(capIsTx), .capPort(capPort),
    .capNs(capNs), .corrValid(corrValid), .corrNs(corrNs),
    .pathAsymmetryNs(pathAsymmetryNs), .peerDelayNs(peerDelayNs));

  task automatic giveVerdict();
    $display("comparisons %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one bus access, entered and left just after a rising edge
  task automatic busCycle(input logic wr, input logic [8:0] addr, input logic [31:0] wd,
    input logic [3:0] be, output logic [31:0] rd);
    int n;
    n = 0;
    avsAddress <= addr;
    avsWrite <= wr;
    avsRead <= ~wr;
    avsWritedata <= wd;
    avsByteenable <= be;
    @(posedge clk);
    while (avsWaitrequest !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    rd = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    if (n >= 20) begin
      errCount++;
      giveVerdict();
    end else begin
      @(posedge clk);
    end
  endtask

  task automatic wr32(input logic [8:0] addr, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] dummy;
    busCycle(1'b1, addr, wd, be, dummy);
  endtask

  task automatic chkRd(input logic [8:0] addr, input logic [31:0] exp);
    logic [31:0] rd;
    busCycle(1'b0, addr, 32'h0000_0000, 4'hF, rd);
    `CHK(rd, exp)
  endtask

  task automatic sel(input logic [2:0] bank, input logic [1:0] port);
    wr32(PTPTS_SEL_OFS, {26'h0, port, 1'b0, bank}, 4'hF);
  endtask

  task automatic pulse(input logic [2:0] rx, tx, rc, tc, input int n);
    rxEv <= rx;
    txEv <= tx;
    rxClr <= rc;
    txClr <= tc;
    repeat (n) @(posedge clk);
    rxEv <= '0;
    txEv <= '0;
    rxClr <= '0;
    txClr <= '0;
    @(posedge clk);
  endtask

  task automatic classify(input logic [1:0] port, input logic [47:0] mac, input logic exp);
    rxDestValid <= 1'b1;
    rxDestPort <= port;
    rxDestMac <= mac;
    @(posedge clk);
    rxDestValid <= 1'b0;
    @(negedge clk);
    `CHK({rxPtpDestValid, rxPtpDest}, {1'b1, exp})
    @(posedge clk);
  endtask

  task automatic correct(input logic tx, input logic [1:0] port, input logic [31:0] ns,
    input logic [31:0] exp);
    capValid <= 1'b1;
    capIsTx <= tx;
    capPort <= port;
    capNs <= ns;
    @(posedge clk);
    capValid <= 1'b0;
    @(negedge clk);
    `CHK({corrValid, corrNs}, {1'b1, exp})
    @(posedge clk);
  endtask

  task automatic testReset();
    chkRd(PTPTS_SEL_OFS, 32'h0000_0000);
    chkRd(PTPTS_ASYM_OFS, 32'h0000_0000);
    chkRd(PTPTS_CAP_OFS, 32'h0000_0000);
    chkRd(PTPTS_LAT_OFS, 32'h0014_0014);
    chkRd(PTPTS_PARSE_OFS, 32'h0000_0000);
    sel(3'h0, 2'h2);
    chkRd(PTPTS_LAT_OFS, 32'h005F_011D);
    sel(3'h1, 2'h2);
    chkRd(PTPTS_PARSE_OFS, 32'h0000_7000);
    chkRd(PTPTS_LAT_OFS, 32'h0000_0000);
    chkRd(PTPTS_ASYM_OFS, 32'h0000_0000);
    chkRd(9'h100, 32'h0000_0000);
  endtask

  task automatic testAsym();
    for (int p = 0; p < 3; p++) begin
      sel(3'h0, p[1:0]);
      wr32(PTPTS_ASYM_OFS, {16'hFFF0 + p[15:0], 16'h0100 + p[15:0]}, 4'hF);
    end
    for (int p = 0; p < 3; p++) begin
      sel(3'h0, p[1:0]);
      chkRd(PTPTS_ASYM_OFS, {16'hFFF0 + p[15:0], 16'h0100 + p[15:0]});
      `CHK(pathAsymmetryNs[p*16+:16], 16'hFFF0 + p[15:0])
      `CHK(peerDelayNs[p*16+:16], 16'h0100 + p[15:0])
    end
    wr32(PTPTS_ASYM_OFS, 32'h00AB_0000, 4'h4);
    chkRd(PTPTS_ASYM_OFS, 32'hFFAB_0102);
    sel(3'h0, 2'h3);
    chkRd(PTPTS_ASYM_OFS, 32'h0000_0000);
  endtask

  task automatic testCounts();
    sel(3'h0, 2'h1);
    pulse(3'h2, 3'h0, 3'h0, 3'h0, 9);
    pulse(3'h0, 3'h2, 3'h0, 3'h0, 2);
    wr32(PTPTS_CAP_OFS, 32'hFFFF_FFFF, 4'hF);
    chkRd(PTPTS_CAP_OFS, 32'h0000_0027);
    sel(3'h0, 2'h0);
    chkRd(PTPTS_CAP_OFS, 32'h0000_0000);
    sel(3'h0, 2'h1);
    pulse(3'h0, 3'h2, 3'h2, 3'h2, 1);
    chkRd(PTPTS_CAP_OFS, 32'h0000_0026);
    pulse(3'h0, 3'h0, 3'h0, 3'h2, 3);
    chkRd(PTPTS_CAP_OFS, 32'h0000_0006);
    pulse(3'h0, 3'h0, 3'h2, 3'h0, 5);
    chkRd(PTPTS_CAP_OFS, 32'h0000_0001);
  endtask

  task automatic testClassify();
    logic [47:0] macs [7];
    macs = '{PTPTS_MAC_L2A, PTPTS_MAC_L2B, PTPTS_MAC_V4_129, PTPTS_MAC_V6_129,
      PTPTS_MAC_V4_130, PTPTS_MAC_V6_130, 48'h0180_C200_000F};
    for (int i = 0; i < 7; i++) begin
      classify(2'h0, macs[i], i < 4);
    end
    sel(3'h1, 2'h0);
    wr32(PTPTS_PARSE_OFS, 32'h0000_0800, 4'hF);
    chkRd(PTPTS_PARSE_OFS, 32'h0000_0800);
    for (int i = 0; i < 7; i++) begin
      classify(2'h0, macs[i], i == 4 || i == 5);
    end
    classify(2'h2, PTPTS_MAC_L2A, 1'b1);
    classify(2'h3, PTPTS_MAC_L2A, 1'b0);
  endtask

  task automatic testCorrect();
    correct(1'b1, 2'h0, 32'h0000_1000, 32'h0000_0FEC);
    correct(1'b0, 2'h1, 32'h0000_1000, 32'h0000_111D);
    correct(1'b1, 2'h2, 32'h0000_0010, 32'hFFFF_FFB1);
    sel(3'h0, 2'h1);
    wr32(PTPTS_LAT_OFS, 32'h0000_0200, 4'h3);
    chkRd(PTPTS_LAT_OFS, 32'h005F_0200);
    correct(1'b0, 2'h1, 32'h0000_1000, 32'h0000_1200);
    correct(1'b1, 2'h1, 32'h0000_1000, 32'h0000_0FA1);
    correct(1'b1, 2'h3, 32'h0000_0010, 32'h0000_0010);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    testReset();
    testAsym();
    testCounts();
    testClassify();
    testCorrect();
    giveVerdict();
  end
endmodule
